// file: tb/sdrv_control_tb_top.sv
// Self-checking bench for the stepping motor driver control logic
`timescale 1ns/10ps
module sdrv_control_tb_top;
   import sdrv_pkg::*;
   localparam int INIT_N = 20;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clock, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire logic   hready;
   logic        driver_reset_n_in, enable_n_in, forward_pulse_or_step_in;
   logic        reverse_pulse_or_direction_in, standstill_current_select_in;
   logic [9:0]  analog_current_level_in, run_current_permille, standstill_current_permille;
   logic        control_power_ok_in, main_power_ok_in, alarm_event_in;
   logic        alarm_out, alarm_oe_n, step_zero_timing_out, step_zero_timing_oe_n;
   logic        pulse_ready_out, pulse_ready_oe_n, motor_excited, step_cw, step_ccw;
   logic        power_alarm_indicator;
   logic [3:0]  excitation_position;
   int          bad_count, tests_run, cw_n, ccw_n;
   // Single slave, so its ready is the bus ready
   assign hready = hreadyout;
   sdrv_control #(.INIT_CYCLES(INIT_N), .BLINK_CYCLES(4)) i_dut (.*);
   sdrv_host_model #(.RESET_LOW(10)) i_host (
      .clock      (clock),
      .ready_oe_n (pulse_ready_oe_n),
      .drst_n     (driver_reset_n_in),
      .en_n       (enable_n_in),
      .fwd        (forward_pulse_or_step_in),
      .rev        (reverse_pulse_or_direction_in)
   );
   // Steps seen on the motor side, counted per direction
   always @(posedge clock) begin
      cw_n  <= cw_n + int'(step_cw);
      ccw_n <= ccw_n + int'(step_ccw);
   end
   // A pulse that never saw ready counts as a mismatch
   always @(posedge clock) begin
      if (i_host.lost) begin
         bad_count++;
         $display("unexpected at %0t: pulse ready wait ran out", $time);
         end_sim;
      end
   end
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task end_sim;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : end_sim
   task wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: bus wait ran out", $time);
         end_sim;
      end
   endtask : wait_ready
   // Address phase held until ready, then data phase until ready
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready;
      rd = hrdata;
   endtask : bus
   task rcheck(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(rd, exp);
      check(32'(hresp), 32'h0);
   endtask : rcheck
   // Pin to output is up to four cycles; eight leaves margin
   task settle;
      repeat (8) @(posedge clock);
   endtask : settle
   // ------------------------------------------------------------
   // Clock and sequence
   // ------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      standstill_current_select_in = 1'b1;
      analog_current_level_in = 10'h000;
      {control_power_ok_in, main_power_ok_in, alarm_event_in} = 3'b110;
      bad_count = 0;
      tests_run = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      repeat (INIT_N + 10) @(posedge clock);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(rd & 32'h3, 32'h1);
      rcheck(ADDR_SOURCE, {29'h0, SOURCE_RESET});
      rcheck(ADDR_LEVEL, 32'h000103e8);
      rcheck(ADDR_RATES, 32'h01f403e8);
      rcheck(8'h20, 32'h0);
      i_host.set_en(1'b0);
      settle;
      check(32'(motor_excited), 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h1);
      settle;
      check(32'(motor_excited), 32'h1);
      check(32'(excitation_position), 32'h0);
      check(32'(step_zero_timing_oe_n), 32'h0);
      check(32'(pulse_ready_oe_n), 32'h0);
      i_host.set_rev(1'b0);
      i_host.pulse(1'b1);
      settle;
      check(32'(excitation_position), 32'h9);
      i_host.set_rev(1'b1);
      i_host.pulse(1'b1);
      i_host.pulse(1'b1);
      settle;
      check(32'(excitation_position), 32'h1);
      check(32'(step_zero_timing_oe_n), 32'h1);
      check(cw_n, 32'h2);
      check(ccw_n, 32'h1);
      bus(1'b1, ADDR_CTRL, 32'h2);
      i_host.pulse(1'b1);
      settle;
      check(32'(excitation_position), 32'h1);
      i_host.set_rev(1'b0);
      i_host.pulse(1'b0);
      settle;
      check(32'(excitation_position), 32'h0);
      i_host.pulse(1'b1);
      settle;
      check(32'(excitation_position), 32'h1);
      check(cw_n, 32'h3);
      check(ccw_n, 32'h2);
      bus(1'b1, ADDR_SOURCE, 32'h0);
      analog_current_level_in <= 10'h190;
      standstill_current_select_in <= 1'b0;
      settle;
      rcheck(ADDR_RATES, 32'h00640190);
      standstill_current_select_in <= 1'b1;
      settle;
      rcheck(ADDR_RATES, 32'h00c80190);
      check(32'(standstill_current_permille), 32'h0c8);
      analog_current_level_in <= 10'h000;
      settle;
      check(32'(run_current_permille), 32'h1);
      main_power_ok_in <= 1'b0;
      settle;
      check(32'(pulse_ready_oe_n), 32'h1);
      check(32'(motor_excited), 32'h0);
      main_power_ok_in <= 1'b1;
      control_power_ok_in <= 1'b0;
      settle;
      check(32'(pulse_ready_oe_n), 32'h1);
      check(32'(motor_excited), 32'h0);
      control_power_ok_in <= 1'b1;
      settle;
      check(32'(motor_excited), 32'h1);
      check(32'(power_alarm_indicator), 32'h1);
      check({29'h0, alarm_out, step_zero_timing_out, pulse_ready_out}, 32'h0);
      alarm_event_in <= 1'b1;
      @(posedge clock);
      alarm_event_in <= 1'b0;
      settle;
      check(32'(alarm_oe_n), 32'h1);
      check(32'(motor_excited), 32'h0);
      check(32'(pulse_ready_oe_n), 32'h1);
      rd = 32'(power_alarm_indicator);
      repeat (4) @(posedge clock);
      check(32'(power_alarm_indicator), rd ^ 32'h1);
      i_host.drv_reset;
      settle;
      check(32'(alarm_oe_n), 32'h0);
      check(32'(excitation_position), 32'h0);
      rcheck(ADDR_SOURCE, {29'h0, SOURCE_RESET});
      repeat (INIT_N + 4) @(posedge clock);
      bus(1'b0, ADDR_STATUS, 32'h0);
      check(rd & 32'h1b, 32'h1);
      bus(1'b1, ADDR_SOURCE, 32'h7);
      bus(1'b1, ADDR_CTRL, 32'h1);
      settle;
      check(32'(motor_excited), 32'h0);
      bus(1'b1, ADDR_CTRL, 32'h4);
      settle;
      check(32'(motor_excited), 32'h1);
      check(32'(pulse_ready_oe_n), 32'h0);
      end_sim;
   end
endmodule : sdrv_control_tb_top

// file: tb/sdrv_host_model.sv
// Host motion controller model driving the driver control pins
`timescale 1ns/10ps
module sdrv_host_model #(
   parameter int RESET_LOW = 10
) (
   // Clock and status
   input  wire logic clock,
   input  wire logic ready_oe_n,
   // Control pins
   output logic      drst_n,
   output logic      en_n,
   output logic      fwd,
   output logic      rev
);
   bit lost;
   initial begin
      drst_n = 1'b1;
      en_n   = 1'b1;
      fwd    = 1'b0;
      rev    = 1'b0;
   end
   // Four cycles per level: every edge is seen and timing output stays valid
   task pulse(input logic on_fwd);
      int n;
      n = 0;
      while (ready_oe_n !== 1'b0 && n < 40) begin
         @(posedge clock);
         n++;
      end
      lost = (n >= 40);
      if (!lost) begin
         fwd <= on_fwd ? 1'b1 : fwd;
         rev <= on_fwd ? rev : 1'b1;
         repeat (4) @(posedge clock);
         fwd <= on_fwd ? 1'b0 : fwd;
         rev <= on_fwd ? rev : 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask : pulse
   task set_rev(input logic v);
      rev <= v;
      repeat (4) @(posedge clock);
   endtask : set_rev
   task set_en(input logic v);
      en_n <= v;
   endtask : set_en
   // Only called with the motor stopped; low time scaled down
   task drv_reset;
      drst_n <= 1'b0;
      repeat (RESET_LOW) @(posedge clock);
      drst_n <= 1'b1;
   endtask : drv_reset
endmodule : sdrv_host_model

// file: verilog/sdrv_control.sv
// Control-signal logic of the stepping motor driver with its register slave
`timescale 1ns/10ps

// Notes on behaviour
// - Standstill current is run current times 50/25%.
// - Standstill pin honoured only when source is pin.
// - Driver reset de-excites, zeroes position, clears all.
// - Reset low 10 ms; ready within 200 ms.
// - Enable low excites only when all conditions hold.
// - One-pulse mode: step per pulse, direction pin.
// - Two-pulse mode: opposite input high blocks stepping.
// - Run current is rated current times 0.1-100%.
// - Analog level used only when run source pin.
// - Alarm opens output, cuts excitation, blinks red.
// - Timing output low at step zero position.
// - Entering operation returns position to step zero.
// - Pulse ready low only under all conditions.
// - Status outputs are open collector.
// - Configuration over four-wire serial link; AHB-Lite register writes stand in for it here.
// - Only go command leaves setting for operation.
module sdrv_control
   import sdrv_pkg::*;
#(
   parameter int unsigned INIT_CYCLES  = sdrv_pkg::INIT_CYCLES_DEF,
   parameter int unsigned BLINK_CYCLES = sdrv_pkg::BLINK_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst,
   // AHB-Lite slave
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic                               hreadyout,
   output logic                               hresp,
   output logic [31:0]                        hrdata,
   // Driver pins
   input  wire logic                          driver_reset_n_in,
   input  wire logic                          enable_n_in,
   input  wire logic                          forward_pulse_or_step_in,
   input  wire logic                          reverse_pulse_or_direction_in,
   input  wire logic                          standstill_current_select_in,
   input  wire logic [sdrv_pkg::ANALOG_W-1:0] analog_current_level_in,
   input  wire logic                          control_power_ok_in,
   input  wire logic                          main_power_ok_in,
   input  wire logic                          alarm_event_in,
   // Open-collector status pins
   output logic                               alarm_out,
   output logic                               alarm_oe_n,
   output logic                               step_zero_timing_out,
   output logic                               step_zero_timing_oe_n,
   output logic                               pulse_ready_out,
   output logic                               pulse_ready_oe_n,
   // Motor side
   output logic                               motor_excited,
   output logic                               step_cw,
   output logic                               step_ccw,
   output logic [sdrv_pkg::POS_W-1:0]         excitation_position,
   output logic [9:0]                         run_current_permille,
   output logic [9:0]                         standstill_current_permille,
   output logic                               power_alarm_indicator
);
   import sdrv_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [PIN_W-1:0] pin_prev;

   assign pin_raw = {analog_current_level_in, alarm_event_in, main_power_ok_in,
                     control_power_ok_in, standstill_current_select_in,
                     reverse_pulse_or_direction_in, forward_pulse_or_step_in,
                     driver_reset_n_in};

   genvar gi;
   generate
      for (gi = 0; gi < PIN_W; gi++) begin : g_sync
         always_ff @(posedge clock) begin
            if (rst) begin
               pin_meta[gi] <= 1'b0;
               pin_sync[gi] <= 1'b0;
               pin_prev[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_sync[gi] <= pin_meta[gi];
               pin_prev[gi] <= pin_sync[gi];
            end
         end
      end
   endgenerate

   // Enable pin idles high, so it resets to the inactive level
   logic enable_meta;
   logic enable_sync;
   always_ff @(posedge clock) begin
      if (rst) begin
         enable_meta <= 1'b1;
         enable_sync <= 1'b1;
      end else begin
         enable_meta <= enable_n_in;
         enable_sync <= enable_meta;
      end
   end

   logic                drv_run;
   logic                fwd_s;
   logic                rev_s;
   logic                ss_pin;
   logic                power_ok;
   logic                alarm_evt;
   logic [ANALOG_W-1:0] analog_s;
   logic                fwd_rise;
   logic                rev_rise;

   assign drv_run   = pin_sync[0];
   assign fwd_s     = pin_sync[1];
   assign rev_s     = pin_sync[2];
   assign ss_pin    = pin_sync[3];
   assign power_ok  = pin_sync[4] & pin_sync[5];
   assign alarm_evt = pin_sync[6];
   assign analog_s  = pin_sync[PIN_W-1:7];
   assign fwd_rise  = pin_sync[1] & ~pin_prev[1];
   assign rev_rise  = pin_sync[2] & ~pin_prev[2];

   // All but the pin synchronisers and bus slave registers is cleared while driver reset is low
   logic clear_all;
   assign clear_all = rst | ~drv_run;

   // ------------------------------------------------------------
   // Register slave
   // ------------------------------------------------------------
   // Bus writes stand in for the four-wire serial configuration link
   logic        wr_pend;
   logic [7:0]  wr_addr;
   logic        go_cmd;
   logic [1:0]  ctrl_q;
   logic [2:0]  source_q;
   logic        serial_half;
   logic [9:0]  serial_run;
   sdrv_state_t state;
   logic        alarm;
   logic        addr_phase;

   assign addr_phase = hsel & hready & htrans[1];

   always_ff @(posedge clock) begin
      if (rst) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= addr_phase & hwrite;
         wr_addr <= haddr[7:0];
      end
   end

   always_ff @(posedge clock) begin
      if (clear_all) begin
         ctrl_q      <= CTRL_RESET;
         source_q    <= SOURCE_RESET;
         serial_half <= 1'b1;
         serial_run  <= RUN_PERMILLE_RESET;
      end else if (wr_pend) begin
         case (wr_addr)
            ADDR_CTRL:   ctrl_q <= hwdata[CTRL_EXCITE_BIT:CTRL_TWO_PULSE];
            ADDR_SOURCE: source_q <= hwdata[2:0];
            ADDR_LEVEL: begin
               serial_half <= hwdata[LVL_HALF_BIT];
               if (hwdata[9:0] > RUN_PERMILLE_MAX)
                  serial_run <= RUN_PERMILLE_MAX;
               else if (hwdata[9:0] < RUN_PERMILLE_MIN)
                  serial_run <= RUN_PERMILLE_MIN;
               else
                  serial_run <= hwdata[9:0];
            end
            default: ;
         endcase
      end
   end

   assign go_cmd = wr_pend & (wr_addr == ADDR_CTRL) & hwdata[CTRL_GO_BIT];

   // Read data prepared in the address phase; zero wait states
   always_ff @(posedge clock) begin
      if (rst) begin
         hrdata    <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         if (addr_phase & ~hwrite) begin
            case (haddr[7:0])
               ADDR_CTRL:   hrdata <= {29'h0, ctrl_q, 1'b0};
               ADDR_SOURCE: hrdata <= {29'h0, source_q};
               ADDR_LEVEL:  hrdata <= {15'h0, serial_half, 6'h0, serial_run};
               ADDR_STATUS: hrdata <= {22'h0, excitation_position, pulse_ready_oe_n,
                                       alarm, motor_excited, power_ok, state};
               ADDR_RATES:  hrdata <= {6'h0, standstill_current_permille, 6'h0,
                                       run_current_permille};
               default:     hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Internal state
   // ------------------------------------------------------------
   logic [31:0] init_cnt;
   sdrv_state_t next_state;

   always_comb begin
      next_state = state;
      case (state)
         SDRV_INIT:    if (init_cnt == INIT_CYCLES - 1) next_state = SDRV_SETTING;
         SDRV_SETTING: if (go_cmd) next_state = SDRV_OPERATE;
         SDRV_OPERATE: next_state = SDRV_OPERATE;
         default:      next_state = SDRV_INIT;
      endcase
   end

   always_ff @(posedge clock) begin
      if (clear_all) begin
         state    <= SDRV_INIT;
         init_cnt <= 32'h0;
      end else begin
         state    <= next_state;
         init_cnt <= (state == SDRV_INIT) ? init_cnt + 32'h1 : 32'h0;
      end
   end

   // Alarm is only released by driver reset or rst
   always_ff @(posedge clock) begin
      if (clear_all)
         alarm <= 1'b0;
      else if (alarm_evt)
         alarm <= 1'b1;
   end

   // ------------------------------------------------------------
   // Excitation and stepping
   // ------------------------------------------------------------
   logic excite_req;
   logic next_excited;
   logic ready;
   logic two_pulse;
   logic step_fwd;
   logic step_rev;

   assign two_pulse  = ctrl_q[0];
   assign excite_req = source_q[SRC_EXCITE] ? ctrl_q[1] : ~enable_sync;
   assign next_excited = excite_req & power_ok & ~alarm & ~alarm_evt
                         & (state == SDRV_OPERATE);
   assign ready = motor_excited & power_ok & ~alarm & (state == SDRV_OPERATE);

   // Pulses outside the ready window are dropped
   assign step_fwd = ready & (two_pulse ? (fwd_rise & ~rev_s)
                                        : (fwd_rise & rev_s));
   assign step_rev = ready & (two_pulse ? (rev_rise & ~fwd_s)
                                        : (fwd_rise & ~rev_s));

   always_ff @(posedge clock) begin
      if (clear_all) begin
         motor_excited <= 1'b0;
         step_cw       <= 1'b0;
         step_ccw      <= 1'b0;
      end else begin
         motor_excited <= next_excited;
         step_cw       <= step_fwd;
         step_ccw      <= step_rev;
      end
   end

   always_ff @(posedge clock) begin
      if (clear_all)
         excitation_position <= POS_ZERO;
      else if (state == SDRV_SETTING && go_cmd)
         excitation_position <= POS_ZERO;
      else if (step_fwd)
         excitation_position <= (excitation_position == POS_LAST) ? POS_ZERO
                                : excitation_position + 4'h1;
      else if (step_rev)
         excitation_position <= (excitation_position == POS_ZERO) ? POS_LAST
                                : excitation_position - 4'h1;
   end

   // ------------------------------------------------------------
   // Current rates
   // ------------------------------------------------------------
   logic [9:0] analog_permille;
   logic [9:0] run_rate;

   // Zero volts still gives the lowest nonzero rate
   assign analog_permille = (analog_s > RUN_PERMILLE_MAX) ? RUN_PERMILLE_MAX :
                            (analog_s < RUN_PERMILLE_MIN) ? RUN_PERMILLE_MIN : analog_s;
   assign run_rate = source_q[SRC_RUN] ? serial_run : analog_permille;

   always_ff @(posedge clock) begin
      if (clear_all) begin
         run_current_permille        <= RUN_PERMILLE_RESET;
         standstill_current_permille <= RUN_PERMILLE_RESET >> 1;
      end else begin
         run_current_permille <= run_rate;
         if (source_q[SRC_STANDSTILL] ? serial_half : ss_pin)
            standstill_current_permille <= run_rate >> 1;
         else
            standstill_current_permille <= run_rate >> 2;
      end
   end

   // ------------------------------------------------------------
   // Open-collector outputs and indicator
   // ------------------------------------------------------------
   // Pins only ever pull low; the enable decides low or open
   logic [31:0] blink_cnt;

   always_ff @(posedge clock) begin
      if (clear_all) begin
         alarm_out             <= 1'b0;
         alarm_oe_n            <= 1'b0;
         step_zero_timing_out  <= 1'b0;
         step_zero_timing_oe_n <= 1'b1;
         pulse_ready_out       <= 1'b0;
         pulse_ready_oe_n      <= 1'b1;
      end else begin
         alarm_out             <= 1'b0;
         alarm_oe_n            <= alarm | alarm_evt;
         step_zero_timing_out  <= 1'b0;
         step_zero_timing_oe_n <= ~(motor_excited
                                    & (excitation_position == POS_ZERO));
         pulse_ready_out       <= 1'b0;
         pulse_ready_oe_n      <= ~ready;
      end
   end

   // Blinks while an alarm is held; otherwise follows power_ok
   always_ff @(posedge clock) begin
      if (clear_all) begin
         blink_cnt             <= 32'h0;
         power_alarm_indicator <= 1'b0;
      end else if (!alarm) begin
         blink_cnt             <= 32'h0;
         power_alarm_indicator <= power_ok;
      end else if (blink_cnt == BLINK_CYCLES - 1) begin
         blink_cnt             <= 32'h0;
         power_alarm_indicator <= ~power_alarm_indicator;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_go_in_setting;
      (state == SDRV_SETTING) && go_cmd && drv_run;
   endsequence
   sequence s_operating_at_zero;
      (state == SDRV_OPERATE) && (excitation_position == POS_ZERO);
   endsequence

   property p_go_zero;
      s_go_in_setting |=> s_operating_at_zero;
   endproperty
   a_go_zero: assert property (p_go_zero) else $error("go did not zero position");

   property p_no_go_no_op;
      (state == SDRV_SETTING) && !go_cmd && drv_run |=> state != SDRV_OPERATE;
   endproperty
   a_no_go_no_op: assert property (p_no_go_no_op) else $error("left setting early");

   property p_drv_reset;
      !drv_run |=> (state == SDRV_INIT) && !alarm && !motor_excited
                   && (excitation_position == POS_ZERO) && (source_q == SOURCE_RESET);
   endproperty
   a_drv_reset: assert property (p_drv_reset) else $error("driver reset incomplete");

   property p_init_bound;
      state == SDRV_INIT |-> init_cnt < INIT_CYCLES;
   endproperty
   a_init_bound: assert property (p_init_bound) else $error("init overran");

   property p_ready_cond;
      !pulse_ready_oe_n |-> $past(motor_excited) && $past(state == SDRV_OPERATE)
                            && !$past(alarm);
   endproperty
   a_ready_cond: assert property (p_ready_cond) else $error("ready without cause");

   property p_alarm_cut;
      alarm_evt && drv_run |=> !motor_excited && alarm_oe_n ##1 alarm_oe_n;
   endproperty
   a_alarm_cut: assert property (p_alarm_cut) else $error("alarm not acted on");

   property p_no_step_unready;
      !ready |=> !step_cw && !step_ccw;
   endproperty
   a_no_step_unready: assert property (p_no_step_unready) else $error("step when unready");

   property p_two_pulse_block;
      ready && two_pulse && fwd_rise && rev_s |=> !step_cw;
   endproperty
   a_two_pulse_block: assert property (p_two_pulse_block) else $error("blocked step taken");

   property p_one_pulse_dir;
      ready && !two_pulse && fwd_rise && rev_s && drv_run |=> step_cw && !step_ccw;
   endproperty
   a_one_pulse_dir: assert property (p_one_pulse_dir) else $error("wrong direction");

   property p_timing_zero;
      motor_excited && (excitation_position == POS_ZERO) && drv_run
         |=> !step_zero_timing_oe_n;
   endproperty
   a_timing_zero: assert property (p_timing_zero) else $error("timing not low at zero");

   property p_standstill_rate;
      drv_run && !source_q[SRC_STANDSTILL] && !ss_pin && $stable(run_rate) && drv_run
         |=> standstill_current_permille == (run_current_permille >> 2);
   endproperty
   a_standstill_rate: assert property (p_standstill_rate) else $error("bad standstill rate");

   property p_run_floor;
      run_current_permille >= RUN_PERMILLE_MIN && run_current_permille <= RUN_PERMILLE_MAX;
   endproperty
   a_run_floor: assert property (p_run_floor) else $error("run rate out of range");

endmodule : sdrv_control

// file: verilog/sdrv_pkg.sv
// Constants for the stepping motor driver control logic
package sdrv_pkg;
   // ------------------------------------------------------------
   // Clock and timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned INIT_TIME_MS     = 200;
   localparam int unsigned INIT_CYCLES_DEF  = INIT_TIME_MS * CLK_MHZ * 1000;
   localparam int unsigned BLINK_TIME_MS    = 250;
   localparam int unsigned BLINK_CYCLES_DEF = BLINK_TIME_MS * CLK_MHZ * 1000;

   // ------------------------------------------------------------
   // Register map (word aligned byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_SOURCE = 8'h04;
   localparam logic [7:0] ADDR_LEVEL  = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_RATES  = 8'h10;

   // CTRL fields
   localparam int CTRL_GO_BIT      = 0;
   localparam int CTRL_TWO_PULSE   = 1;
   localparam int CTRL_EXCITE_BIT  = 2;
   // SOURCE fields: 1 = serial value, 0 = pin
   localparam int SRC_STANDSTILL   = 0;
   localparam int SRC_RUN          = 1;
   localparam int SRC_EXCITE       = 2;
   localparam logic [2:0] SOURCE_RESET = 3'h3;
   localparam logic [1:0] CTRL_RESET   = 2'h0;
   // LEVEL fields
   localparam int LVL_HALF_BIT     = 16;
   localparam logic [9:0] RUN_PERMILLE_RESET = 10'h3e8;
   localparam logic [9:0] RUN_PERMILLE_MIN   = 10'h001;
   localparam logic [9:0] RUN_PERMILLE_MAX   = 10'h3e8;

   // ------------------------------------------------------------
   // Motion
   // ------------------------------------------------------------
   localparam int          POS_W        = 4;
   localparam logic [3:0]  POS_LAST     = 4'h9;
   localparam logic [3:0]  POS_ZERO     = 4'h0;
   localparam int          ANALOG_W     = 10;
   localparam int          PIN_W        = 7 + ANALOG_W;

   typedef enum logic [1:0] {
      SDRV_INIT    = 2'b00,
      SDRV_SETTING = 2'b01,
      SDRV_OPERATE = 2'b10
   } sdrv_state_t;
endpackage : sdrv_pkg
